// ===== hdl/arm_trigger_map.vh
// Constants for the arming and trigger-qualification block
`ifndef ARM_TRIGGER_MAP_VH
`define ARM_TRIGGER_MAP_VH
// Register indices
`define REG_SOURCE 4'h0
`define REG_SENSE 4'h1
`define REG_POLARITY 4'h2
`define REG_ARM_PERIOD 4'h3
`define REG_PULSE_PERIOD 4'h4
`define REG_PERIOD_SELECT 4'h5
`define REG_MANUAL 4'h6
`define REG_STATUS 4'h7
// Source codes
`define SRC_CONTINUOUS_RUN 3'h0
`define SRC_INTERNAL1 3'h1
`define SRC_INTERNAL_ARM_OSCILLATOR 3'h2
`define SRC_EXTERNAL_ARM_INPUT 3'h3
`define SRC_MANUAL 3'h4
// Sense and polarity codes
`define SENSE_EDGE 1'h0
`define SENSE_LEVEL 1'h1
`define POL_POSITIVE 2'h0
`define POL_NEGATIVE 2'h1
`define POL_EITHER 2'h2
// Period limits and default in picoseconds, clock period in picoseconds
`define CLOCK_PERIOD_PS 4000
`define ARM_PERIOD_MIN_PS 6060
`define ARM_PERIOD_DEFAULT_PS 10000000
// Cycle counts derived from the times above
`define ARM_PERIOD_MIN_CYC ((`ARM_PERIOD_MIN_PS + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)
`define ARM_PERIOD_DEFAULT_CYC (`ARM_PERIOD_DEFAULT_PS / `CLOCK_PERIOD_PS)
`endif

// ===== hdl/arm_oscillator.v
// Programmable-period square-wave arming oscillator
`timescale 1ns/10ps
module arm_oscillator #(
	parameter WIDTH = 38
) (
	input wire clock,
	input wire reset_n,
	input wire [WIDTH-1:0] halfPeriod,
	output reg oscOut
);
	reg [WIDTH-1:0] count;

	// Toggle every halfPeriod cycles; a new period applies at once to the half period in progress
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count <= {WIDTH{1'b0}};
			oscOut <= 1'b0;
		end else if (count + {{(WIDTH-1){1'b0}}, 1'b1} >= halfPeriod) begin
			count <= {WIDTH{1'b0}};
			oscOut <= ~oscOut;
		end else begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule // arm_oscillator

// ===== hdl/arm_trigger_control.v
// Arming source selection and trigger qualification
// One of five arming sources is picked, qualified by edge or by level and
// turned into start events for the pulse engine. Period words count clock
// cycles; the analog threshold of the external input sits in front of the pin.
// Reset leaves the block in continuous run with edge sense and positive polarity.
//
// Contract
// R1 - Internal oscillator period programmable, default 10us
// R2 - Pulse-period source follows pulse-period setting
// R3 - Edge mode triggers on selected crossing
// R4 - Level mode triggers while signal active
// R5 - Either polarity triggers on both edges
// R6 - Level polarity picks high or low phase
// R7 - Five sources: continuous_run, int1, int2, ext, manual
// R8 - Edge is triggered, level is gated
// R9 - Synchronise external and manual inputs first
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`include "arm_trigger_map.vh"
module arm_trigger_control #(
	parameter PERIOD_WIDTH = 40,
	parameter [39:0] ARM_PERIOD_DEFAULT = `ARM_PERIOD_DEFAULT_CYC
) (
	input wire clock,
	input wire reset_n,
	input wire [3:0] address,
	input wire [31:0] writeData,
	input wire writeStrobe,
	input wire readStrobe,
	output reg [31:0] readData,
	input wire externalArmInput,
	input wire manualKey,
	output reg startEvent,
	output reg gatedMode,
	output reg oscillatorOut
);
	localparam [PERIOD_WIDTH-1:0] PERIOD_MIN = `ARM_PERIOD_MIN_CYC;

	// Settings written by software
	reg [2:0] armSourceSelect;
	reg armSenseSelect;
	reg [1:0] armPolaritySelect;
	reg [PERIOD_WIDTH-1:0] armOscillatorPeriod;
	reg [PERIOD_WIDTH-1:0] pulsePeriod;
	reg periodSelect;
	reg manualPulse;
	reg [31:0] next_readData;
	reg [PERIOD_WIDTH-1:0] clampedPeriod;
	wire [PERIOD_WIDTH-1:0] writePeriod;

	// Arming pipeline: oscillator, synchronised pins, selected signal
	wire oscSignal;
	wire [1:0] rawArm;
	wire [1:0] syncLevel;
	reg softTrigger;
	wire extLevel;
	wire manLevel;
	genvar k;
	reg armSignal;
	reg armPrev;
	reg next_start;

	// Period words are written in cycles; values below the minimum are raised to it
	// The upper bits stay zero, so the longest period is 2^32-1 cycles
	assign writePeriod = {{(PERIOD_WIDTH-32){1'b0}}, writeData};

	// Register writes; out-of-range source and polarity codes are dropped
	// rather than aliased, so a stray write cannot select a mode that does not exist
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			armSourceSelect <= `SRC_CONTINUOUS_RUN;
			armSenseSelect <= `SENSE_EDGE;
			armPolaritySelect <= `POL_POSITIVE;
			armOscillatorPeriod <= ARM_PERIOD_DEFAULT[PERIOD_WIDTH-1:0]; // [R1]
			pulsePeriod <= ARM_PERIOD_DEFAULT[PERIOD_WIDTH-1:0];
			periodSelect <= 1'b0;
			manualPulse <= 1'b0;
		end else begin
			manualPulse <= 1'b0;
			if (writeStrobe) begin
				case (address)
					`REG_SOURCE: begin
						if (writeData[2:0] <= `SRC_MANUAL)
							armSourceSelect <= writeData[2:0]; // [R7]
					end
					`REG_SENSE: armSenseSelect <= writeData[0];
					`REG_POLARITY: begin
						if (writeData[1:0] != 2'h3)
							armPolaritySelect <= writeData[1:0];
					end
					`REG_ARM_PERIOD: armOscillatorPeriod <= (writePeriod < PERIOD_MIN) ? PERIOD_MIN : writePeriod; // [R1]
					`REG_PULSE_PERIOD: pulsePeriod <= (writePeriod < PERIOD_MIN) ? PERIOD_MIN : writePeriod;
					`REG_PERIOD_SELECT: periodSelect <= writeData[0];
					`REG_MANUAL: manualPulse <= writeData[0];
					default: ;
				endcase
			end
		end
	end

	// Oscillator period: pulse-period setting when it serves as pulse source
	// The switch applies at once to the half period in progress, so that half period may come out short or long
	always @* begin
		clampedPeriod = periodSelect ? pulsePeriod : armOscillatorPeriod; // [R2]
	end

	// Half the period feeds the toggle counter; an odd period loses one cycle,
	// and at the minimum of two cycles the square wave toggles on every clock
	arm_oscillator #(
		.WIDTH(PERIOD_WIDTH-1)
	) oscillator (
		.clock(clock),
		.reset_n(reset_n),
		.halfPeriod(clampedPeriod[PERIOD_WIDTH-1:1]),
		.oscOut(oscSignal)
	);

	// Three-stage synchronisers, one per asynchronous arming pin; a change counts
	// only when stages two and three agree, so a glitch shorter than a cycle is dropped
	assign rawArm = {manualKey, externalArmInput};

	generate
		for (k = 0; k < 2; k = k + 1) begin : armSync
			reg [2:0] stage;
			reg settled;
			// Only the second stage reads the first; the first may go metastable
			always @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					stage <= 3'h0;
					settled <= 1'b0;
				end else begin
					stage <= {stage[1:0], rawArm[k]}; // [R9]
					if (stage[1] == stage[2])
						settled <= stage[2]; // [R9]
				end
			end
			assign syncLevel[k] = settled;
		end
	endgenerate

	// Software trigger becomes one clock of manual level; it already belongs
	// to the clock domain, so it bypasses the synchroniser
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			softTrigger <= 1'b0;
		else
			softTrigger <= manualPulse;
	end

	// Source levels after the synchronisers
	assign extLevel = syncLevel[0];
	assign manLevel = syncLevel[1] | softTrigger;

	// Pick the arming signal for the selected source
	// Continuous sources hold it high; their start comes from the qualifier
	always @* begin
		case (armSourceSelect)
			`SRC_INTERNAL_ARM_OSCILLATOR: armSignal = oscSignal;
			`SRC_EXTERNAL_ARM_INPUT: armSignal = extLevel;
			`SRC_MANUAL: armSignal = manLevel;
			default: armSignal = 1'b1;
		endcase
	end

	// Qualify by edge or level and polarity. A change of source can look like an
	// edge for one cycle, as armPrev still holds the old source; let it settle first
	always @* begin
		next_start = 1'b0;
		if (armSourceSelect == `SRC_CONTINUOUS_RUN || armSourceSelect == `SRC_INTERNAL1) begin
			next_start = 1'b1; // [R7]
		end else if (armSenseSelect == `SENSE_EDGE) begin
			case (armPolaritySelect)
				`POL_NEGATIVE: next_start = armPrev & ~armSignal; // [R3]
				`POL_EITHER: next_start = armPrev ^ armSignal; // [R5]
				default: next_start = ~armPrev & armSignal; // [R3]
			endcase
		end else begin
			next_start = (armPolaritySelect == `POL_NEGATIVE) ? ~armSignal : armSignal; // [R4] [R6]
		end
	end

	// Outputs registered; gated mode flag follows the sense setting
	// Registering costs a cycle of latency but keeps mux glitches off the outputs
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			armPrev <= 1'b0;
			startEvent <= 1'b0;
			gatedMode <= 1'b0;
			oscillatorOut <= 1'b0;
		end else begin
			armPrev <= armSignal;
			startEvent <= next_start;
			gatedMode <= (armSenseSelect == `SENSE_LEVEL); // [R8]
			oscillatorOut <= oscSignal;
		end
	end

	// Read mux; unmapped addresses read zero
	// Status shows the live arming signals, so two reads may differ
	always @* begin
		next_readData = 32'h0;
		case (address)
			`REG_SOURCE: next_readData = {29'h0, armSourceSelect};
			`REG_SENSE: next_readData = {31'h0, armSenseSelect};
			`REG_POLARITY: next_readData = {30'h0, armPolaritySelect};
			`REG_ARM_PERIOD: next_readData = armOscillatorPeriod[31:0];
			`REG_PULSE_PERIOD: next_readData = pulsePeriod[31:0];
			`REG_PERIOD_SELECT: next_readData = {31'h0, periodSelect};
			`REG_STATUS: next_readData = {28'h0, manLevel, extLevel, oscSignal, armSignal};
			default: next_readData = 32'h0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	// and is zero otherwise, so a late sample shows a plain zero, never stale data
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			readData <= 32'h0;
		else if (readStrobe)
			readData <= next_readData;
		else
			readData <= 32'h0;
	end
endmodule // arm_trigger_control

// ===== tb/arm_source_model.sv
// Far-side model: external arming source and manual key
`timescale 1ns/10ps
module arm_source_model (
	input wire extLevel,
	input wire keyLevel,
	output reg externalArmInput = 1'b0,
	output reg manualKey = 1'b0
);
	// Pins move off the clock grid, as an asynchronous source does
	always @(extLevel) externalArmInput <= #1.3 extLevel;
	always @(keyLevel) manualKey <= #2.7 keyLevel;
endmodule // arm_source_model

// ===== tb/arm_trigger_control_assertions.sv
// Checker for the arming and trigger block
`timescale 1ns/10ps
module arm_trigger_control_assertions (
	input wire clock,
	input wire reset_n,
	input wire [3:0] address,
	input wire [31:0] writeData,
	input wire writeStrobe,
	input wire readStrobe,
	input wire [31:0] readData,
	input wire externalArmInput,
	input wire manualKey,
	input wire startEvent,
	input wire gatedMode,
	input wire oscillatorOut
);
	reg [2:0] src;
	reg [1:0] pol, age;
	wire pin = externalArmInput;
	wire e = age == 2'h3 && src == 3'h3 && !gatedMode;
	wire g = age == 2'h3 && src == 3'h3 && gatedMode && !pol[1];
	default clocking d @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	// Shadow settings; age restarts on writes so the input pipeline drains first
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			{src, pol, age} <= 7'h0;
		end else begin
			age <= writeStrobe ? 2'h0 : age + {1'b0, age != 2'h3};
			if (writeStrobe && address == 4'h0 && writeData[2:0] < 3'h5) src <= writeData[2:0];
			if (writeStrobe && address == 4'h2 && writeData[1:0] != 2'h3) pol <= writeData[1:0];
		end
	end
	a_continuous_run: assert property (age == 2'h3 && src < 3'h2 |-> startEvent) else $error("idle");
	a_read_source: assert property (readStrobe && address == 4'h0 |=> readData == $past(src)) else $error("src");
	a_sense_mode: assert property (writeStrobe && address == 4'h1 |-> ##2 gatedMode == $past(writeData[0], 2))
		else $error("mode");
	a_edge_single: assert property (e && startEvent |=> !startEvent) else $error("long");
	a_edge_quiet: assert property ((e && $stable(pin))[*8] |-> !startEvent) else $error("spurious");
	a_edge_fires: assert property (e && (pol == 2'h2 ? $changed(pin) : $rose(pin ^ pol[0])) |-> ##[1:8] startEvent)
		else $error("missed");
	a_sync_delay: assert property ((e && $stable(pin))[*8] ##1 $changed(pin) |=> !startEvent[*2]) else $error("early");
	a_level_gate: assert property ((g && $stable(pin))[*8] |-> startEvent == (pin ^ pol[0])) else $error("gate");
	a_osc_edge: assert property (age == 2'h3 && src == 3'h2 && !gatedMode && pol == 2'h0
		|-> startEvent == $rose(oscillatorOut)) else $error("osc");
	c_level: cover property (g && startEvent);
	c_either: cover property (e && pol == 2'h2 && startEvent);
	c_read: cover property (readStrobe && address == 4'h0);
endmodule // arm_trigger_control_assertions
bind arm_trigger_control arm_trigger_control_assertions chk0 (.*);

// ===== tb/arm_trigger_control_test.sv
// Bench for the arming and trigger block
`timescale 1ns/10ps
module arm_trigger_control_test;
	reg clock = 1'b0, reset_n = 1'b0, writeStrobe = 1'b0, readStrobe = 1'b0, extLevel = 1'b0, keyLevel = 1'b0;
	reg [3:0] address = 4'h0;
	reg [31:0] writeData = 32'h0;
	wire [31:0] readData;
	wire externalArmInput, manualKey, startEvent, gatedMode, oscillatorOut;
	integer seed = 32'hBB515E5C, nFail = 0, nCompared = 0, starts = 0, cycles = 0, rises = 0, n, p, i, base, baseRise;
	reg oscPrev = 1'b0;
	arm_source_model far (.*);
	arm_trigger_control #(.ARM_PERIOD_DEFAULT(40'h8)) dut (.*);
	initial forever #2 clock = ~clock;
	// Start pulses and oscillator rises counted per cycle; the cycle count cuts a hang short
	always @(posedge clock) begin
		starts <= starts + (startEvent === 1'b1);
		oscPrev <= oscillatorOut;
		rises <= rises + (oscillatorOut === 1'b1 && oscPrev === 1'b0);
		cycles <= cycles + 1;
		if (cycles == 20000) endOfTest;
	end
	task chk(input [31:0] got, input [31:0] want);
		nCompared = nCompared + 1;
		if (got !== want) begin
			nFail = nFail + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	// One bus cycle; read data is compared in the cycle after the strobe
	task bus(input r, input [3:0] a, input [31:0] d);
		@(posedge clock);
		address <= a;
		writeData <= d;
		{readStrobe, writeStrobe} <= {r, !r};
		@(posedge clock);
		{readStrobe, writeStrobe} <= 2'h0;
		#1 if (r) chk(readData, d);
	endtask
	// Count starts over n random-width pin pulses, or 48 idle cycles when n is 0
	task run(input integer n, input integer want);
		repeat (8) @(posedge clock);
		#1 base = starts;
		baseRise = rises;
		repeat (2 * n) begin
			{extLevel, keyLevel} <= ~{extLevel, keyLevel};
			repeat (10 + {$random(seed)} % 8) @(posedge clock);
		end
		repeat (n ? 0 : 48) @(posedge clock);
		#1 chk(starts - base, want);
	endtask
	task endOfTest;
		nFail = nFail + (cycles >= 20000);
		$display("compared %0d failed %0d", nCompared, nFail);
		if (nFail == 0 && nCompared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		bus(1, 4'h0, 32'h0);
		chk(startEvent, 32'h1);
		bus(0, 4'h0, 32'h1);
		run(0, 48);
		bus(1, 4'h3, 32'h8);
		bus(0, 4'h0, 32'h2);
		run(0, 6);
		chk(rises - baseRise, 32'h6);
		bus(0, 4'h4, 32'h4);
		bus(0, 4'h5, 32'h1);
		run(0, 12);
		chk(rises - baseRise, 32'hC);
		bus(0, 4'h5, 32'h0);
		for (i = 0; i < 6; i = i + 1) begin
			p = i % 3;
			n = 1 + {$random(seed)} % 4;
			bus(0, 4'h0, 3 + i / 3);
			bus(0, 4'h2, p);
			run(n, p == 2 ? 2 * n : n);
		end
		bus(0, 4'h2, 32'h0);
		base = starts;
		bus(0, 4'h6, 32'h1);
		repeat (8) @(posedge clock);
		#1 chk(starts - base, 32'h1);
		bus(0, 4'h0, 32'h3);
		bus(0, 4'h1, 32'h1);
		for (i = 0; i < 4; i = i + 1) begin
			bus(0, 4'h2, i / 2);
			{extLevel, keyLevel} <= {2{i[0]}};
			repeat (12) @(posedge clock);
			#1 chk({gatedMode, startEvent}, {1'b1, i[0] ^ i[1]});
		end
		bus(0, 4'h0, 32'h7);
		bus(1, 4'h0, 32'h3);
		bus(1, 4'h8, 32'h0);
		bus(0, 4'h4, 32'h1);
		bus(1, 4'h4, 32'h2);
		endOfTest;
	end
endmodule // arm_trigger_control_test
